// *** src/fps_cfg.svh ***
// fps_cfg.svh: bit positions, key values, operation codes and timing for the flash sequencer.
// assumes inclusion by the package, the holding buffer, the sequencer and the property module.
`ifndef FPS_CFG_SVH
`define FPS_CFG_SVH

// ----------------------------------------------------------------
// control register layout
// ----------------------------------------------------------------
`define FPS_GO_BIT          15
`define FPS_ENABLE_BIT      14
`define FPS_FAULT_BIT       13
`define FPS_ERASE_BIT       6
`define FPS_OP_HI           3
`define FPS_OP_LO           0
`define FPS_CTRL_WMASK      16'h404F
`define FPS_CTRL_RESET      16'h0000

// ----------------------------------------------------------------
// unlock keys and operation codes
// ----------------------------------------------------------------
`define FPS_KEY_FIRST       8'h55
`define FPS_KEY_SECOND      8'hAA
`define FPS_OP_BULK         4'hF
`define FPS_OP_GENERAL      4'hD
`define FPS_OP_SECURE       4'hC
`define FPS_OP_WORD         4'h3
`define FPS_OP_PAGE         4'h2
`define FPS_OP_ROW          4'h1
`define FPS_OP_CONFIG       4'h0

// ----------------------------------------------------------------
// timing: cycle time 4 ns at 250 MHz
// ----------------------------------------------------------------
`define FPS_CLK_NS          4
`define FPS_CYCLE_US        4000
`define FPS_CYCLE_CLKS      ((`FPS_CYCLE_US * 1000) / `FPS_CLK_NS)
`define FPS_ROW_WORDS       64
`define FPS_ADDR_W          6

`endif

// *** src/fps_pkg.sv ***
// fps_pkg.sv: types shared by the flash sequencer files.
// assumes fps_cfg.svh is on the include path.
`include "fps_cfg.svh"

package fps_pkg;

    typedef enum logic [2:0] {
        FPS_NONE,
        FPS_PAGE_ERASE,
        FPS_ROW_PROGRAM,
        FPS_WORD_PROGRAM,
        FPS_BULK_ERASE,
        FPS_GENERAL_ERASE,
        FPS_SECURE_ERASE,
        FPS_CONFIG_ACCESS
    } fps_op_t;

    // one holding buffer entry: 24-bit instruction
    typedef struct packed {
        logic [7:0]  high_byte;
        logic [15:0] low_word;
    } fps_word_t;

    // command handed to the flash array
    typedef struct packed {
        fps_op_t op;
        logic    erase;
    } fps_cmd_t;

endpackage

// *** src/fps_hold_buf.sv ***
// fps_hold_buf.sv: row holding buffers, 64 instructions, separate low/high write lanes.
// assumes one writer and one reader on the same clock; read data registered.
`include "fps_cfg.svh"

module fps_hold_buf
    import fps_pkg::*;
(
    input  wire logic                     mclk,
    input  wire logic                     low_we,
    input  wire logic                     high_we,
    input  wire logic [`FPS_ADDR_W-1:0]   wr_addr,
    input  wire logic [15:0]              low_data,
    input  wire logic [7:0]               high_data,
    input  wire logic [`FPS_ADDR_W-1:0]   rd_addr,
    output      fps_word_t                rd_data
);

    fps_word_t mem [`FPS_ROW_WORDS];

    // no reset: contents are undefined until software loads them
    always_ff @(posedge mclk) begin
        if (low_we) begin
            mem[wr_addr].low_word <= low_data;
        end
        if (high_we) begin
            mem[wr_addr].high_byte <= high_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule // fps_hold_buf

// *** src/fps_sequencer.sv ***
// fps_sequencer.sv: flash program/erase sequencer with unlock key, stall and self-timed cycle.
// assumes the core writes control and key one access per cycle and honours cpu_stall.
`include "fps_cfg.svh"

module fps_sequencer
    import fps_pkg::*;
#(
    parameter int unsigned CYCLE_CLKS = `FPS_CYCLE_CLKS
)
(
    input  wire logic                     mclk,
    input  wire logic                     rst_b,
    input  wire logic                     ctrl_we,
    input  wire logic [15:0]              ctrl_wdata,
    input  wire logic                     key_we,
    input  wire logic [7:0]               key_wdata,
    input  wire logic                     low_store,
    input  wire logic                     high_store,
    input  wire logic [`FPS_ADDR_W-1:0]   store_addr,
    input  wire logic [15:0]              store_low,
    input  wire logic [7:0]               store_high,
    input  wire logic                     abort,
    output      logic [15:0]              flash_control_reg,
    output      logic                     cpu_stall,
    output      logic                     array_busy,
    output      fps_cmd_t                 array_cmd,
    output      logic                     array_we,
    output      logic [`FPS_ADDR_W-1:0]   array_addr,
    output      fps_word_t                array_wdata,
    output      logic                     op_done
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} fps_key_t;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} fps_state_t;

    fps_key_t   key_state;
    fps_key_t   next_key_state;
    fps_state_t state;
    logic [31:0] timer;
    logic [`FPS_ADDR_W-1:0] rd_addr;
    logic        stream_on;
    // buffer read data lags its address by one cycle; this marks it valid
    logic        rd_valid;
    fps_word_t   buf_rd;

    wire        go_attempt  = ctrl_we && ctrl_wdata[`FPS_GO_BIT] && (state == ST_IDLE);
    wire        key_ok      = (key_state == KEY_ARMED);
    wire        go_valid    = go_attempt && key_ok && ctrl_wdata[`FPS_ENABLE_BIT];
    wire        go_bad      = go_attempt && !go_valid;
    // abort anywhere in a stalled cycle, the closing cycle too, counts as improper
    wire        abort_bad   = abort && (state != ST_IDLE);
    wire        cycle_end   = (state == ST_RUN) && (timer == 32'(CYCLE_CLKS - 1));

    // operation decode from the value being written with go
    wire        w_erase     = ctrl_wdata[`FPS_ERASE_BIT];
    wire [3:0]  w_op        = ctrl_wdata[`FPS_OP_HI:`FPS_OP_LO];
    fps_op_t    w_kind;
    always_comb begin
        w_kind = FPS_NONE;
        if (w_erase) begin
            unique case (w_op)
                `FPS_OP_BULK:    w_kind = FPS_BULK_ERASE;
                `FPS_OP_GENERAL: w_kind = FPS_GENERAL_ERASE;
                `FPS_OP_SECURE:  w_kind = FPS_SECURE_ERASE;
                `FPS_OP_PAGE:    w_kind = FPS_PAGE_ERASE;
                `FPS_OP_CONFIG:  w_kind = FPS_CONFIG_ACCESS;
                default:         w_kind = FPS_NONE;
            endcase
        end else begin
            unique case (w_op)
                `FPS_OP_WORD:    w_kind = FPS_WORD_PROGRAM;
                `FPS_OP_ROW:     w_kind = FPS_ROW_PROGRAM;
                `FPS_OP_CONFIG:  w_kind = FPS_CONFIG_ACCESS;
                default:         w_kind = FPS_NONE;
            endcase
        end
    end

    // key tracker: 55h arms half, AAh completes, anything else drops it
    always_comb begin
        next_key_state = key_state;
        if (key_we) begin
            if (key_wdata == `FPS_KEY_FIRST) begin
                next_key_state = KEY_HALF;
            end else if (key_wdata == `FPS_KEY_SECOND && key_state == KEY_HALF) begin
                next_key_state = KEY_ARMED;
            end else begin
                next_key_state = KEY_IDLE;
            end
        end else if (ctrl_we || low_store || high_store) begin
            next_key_state = KEY_IDLE;
        end
    end

    // ----------------------------------------------------------------
    // holding buffers
    // ----------------------------------------------------------------
    fps_hold_buf u_buf (
        .mclk      (mclk),
        .low_we    (low_store && state == ST_IDLE),
        .high_we   (high_store && state == ST_IDLE),
        .wr_addr   (store_addr),
        .low_data  (store_low),
        .high_data (store_high),
        .rd_addr   (rd_addr),
        .rd_data   (buf_rd)
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            key_state <= KEY_IDLE;
        end else begin
            key_state <= next_key_state;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state      <= ST_IDLE;
            timer      <= '0;
            array_cmd  <= '{op: FPS_NONE, erase: 1'b0};
            cpu_stall  <= 1'b0;
            array_busy <= 1'b0;
            op_done    <= 1'b0;
        end else begin
            op_done <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (go_valid) begin
                        state      <= ST_RUN;
                        timer      <= '0;
                        array_cmd  <= '{op: w_kind, erase: w_erase};
                        cpu_stall  <= 1'b1;
                        array_busy <= (w_kind != FPS_NONE);
                    end
                end
                ST_RUN: begin
                    timer <= timer + 32'd1;
                    if (cycle_end || abort_bad) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state      <= ST_IDLE;
                    cpu_stall  <= 1'b0;
                    array_busy <= 1'b0;
                    array_cmd  <= '{op: FPS_NONE, erase: 1'b0};
                    op_done    <= 1'b1;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // control register: go self-clears, fault sticky until software writes it
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            flash_control_reg <= `FPS_CTRL_RESET;
        end else begin
            if (ctrl_we && state == ST_IDLE) begin
                flash_control_reg <= (ctrl_wdata & `FPS_CTRL_WMASK)
                                   | (ctrl_wdata & (16'h1 << `FPS_FAULT_BIT));
                flash_control_reg[`FPS_GO_BIT] <= go_valid;
            end
            if (state == ST_DONE) begin
                flash_control_reg[`FPS_GO_BIT] <= 1'b0;
            end
            // set wins over a clearing write in the same cycle
            if (go_bad || abort_bad) begin
                flash_control_reg[`FPS_FAULT_BIT] <= 1'b1;
            end
        end
    end

    // row program streams the 64 buffered words to the array at cycle start
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_addr     <= '0;
            stream_on   <= 1'b0;
            rd_valid    <= 1'b0;
            array_we    <= 1'b0;
            array_addr  <= '0;
            array_wdata <= '0;
        end else begin
            // no word leaves once the cycle is closing, so a cut stream stays inside busy
            rd_valid    <= stream_on;
            array_we    <= rd_valid && (state == ST_RUN);
            array_addr  <= rd_addr - `FPS_ADDR_W'(1);
            array_wdata <= buf_rd;
            if (go_valid && w_kind == FPS_ROW_PROGRAM) begin
                stream_on <= 1'b1;
                rd_addr   <= '0;
            end else if (stream_on) begin
                rd_addr <= rd_addr + `FPS_ADDR_W'(1);
                if (rd_addr == `FPS_ADDR_W'(`FPS_ROW_WORDS - 1) || state != ST_RUN) begin
                    stream_on <= 1'b0;
                end
            end
        end
    end

endmodule // fps_sequencer

// *** testbench/fps_properties.sv ***
// fps_properties.sv: port-level checks on fps_sequencer.
// assumes the bind below; one clock mclk, async active-low rst_b.
`include "fps_cfg.svh"
module fps_properties
    import fps_pkg::*;
#(
    parameter int unsigned CYCLE_CLKS = 20
)
(
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        ctrl_we,
    input wire logic [15:0] ctrl_wdata,
    input wire logic        key_we,
    input wire logic [7:0]  key_wdata,
    input wire logic        low_store,
    input wire logic        high_store,
    input wire logic        abort,
    input wire logic [15:0] flash_control_reg,
    input wire logic        cpu_stall,
    input wire logic        array_busy,
    input wire fps_cmd_t    array_cmd,
    input wire logic        array_we,
    input wire logic        op_done
);
    localparam int LO = CYCLE_CLKS;
    localparam int HI = CYCLE_CLKS + 3;
    logic        half;
    logic        armed;
    int unsigned cnt;
    wire logic   go = ctrl_we && ctrl_wdata[15] && !cpu_stall;
    wire logic   ok = go && armed && ctrl_wdata[14];
    // any access between the two keys and go drops the unlock
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            half  <= 1'b0;
            armed <= 1'b0;
        end else if (key_we || ctrl_we || low_store || high_store) begin
            half  <= key_we && key_wdata == `FPS_KEY_FIRST;
            armed <= key_we && half && key_wdata == `FPS_KEY_SECOND;
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) cnt <= 0;
        else cnt <= cpu_stall ? cnt + 1 : 0;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    chk_valid_go_start: assert property (ok |=> cpu_stall && flash_control_reg[15])
        else $error("valid go did not start a cycle");
    chk_bad_go_fault: assert property (go && !ok |=> flash_control_reg[13] && !cpu_stall)
        else $error("improper go not faulted");
    chk_page_erase_cmd: assert property (ok && ctrl_wdata[6:0] == 7'h42 |=> array_cmd.op == FPS_PAGE_ERASE)
        else $error("page erase not issued");
    chk_row_prog_cmd: assert property (ok && ctrl_wdata[6:0] == 7'h01 |=> array_cmd.op == FPS_ROW_PROGRAM)
        else $error("row program not issued");
    chk_noop_quiet: assert property (ok && ctrl_wdata[6:0] == 7'h43 |=> cpu_stall && !array_busy)
        else $error("no-op code drove the array");
    chk_go_tracks_stall: assert property (cpu_stall == flash_control_reg[15])
        else $error("go bit and stall disagree");
    chk_done_clears_go: assert property (op_done |-> !flash_control_reg[15] && $past(cpu_stall))
        else $error("go not cleared at completion");
    chk_cycle_length: assert property (op_done && !$past(abort) && !$past(abort, 2) |-> cnt >= LO && cnt <= HI)
        else $error("cycle length wrong");
    chk_stall_bound: assert property (cnt <= HI)
        else $error("stall too long");
    chk_abort_ends: assert property (abort && cpu_stall |=> flash_control_reg[13] ##1 !cpu_stall)
        else $error("abort not faulted");
    chk_run_holds_ctrl: assert property (cpu_stall && !op_done && !abort |=> $stable(flash_control_reg[14:0]))
        else $error("control changed while running");
    chk_stream_row: assert property (array_we |-> array_busy && array_cmd.op == FPS_ROW_PROGRAM)
        else $error("word stream outside row program");
endmodule // fps_properties

bind fps_sequencer fps_properties #(.CYCLE_CLKS(CYCLE_CLKS)) u_props (.mclk(mclk), .rst_b(rst_b),
    .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata), .key_we(key_we), .key_wdata(key_wdata),
    .low_store(low_store), .high_store(high_store), .abort(abort), .flash_control_reg(flash_control_reg),
    .cpu_stall(cpu_stall), .array_busy(array_busy), .array_cmd(array_cmd), .array_we(array_we),
    .op_done(op_done));

// *** testbench/fps_core_model.sv ***
// fps_core_model.sv: core side of the sequencer, one access per task, two in put_word and three in unlock_go.
// assumes the caller waits out the stall before the next access.
module fps_core_model (
    input  wire logic mclk,
    output logic      ctrl_we,
    output logic [15:0] ctrl_wdata,
    output logic      key_we,
    output logic [7:0] key_wdata,
    output logic      low_store,
    output logic      high_store,
    output logic [5:0] store_addr,
    output logic [15:0] store_low,
    output logic [7:0] store_high
);
    timeunit 1ns;
    timeprecision 1ps;
    // released data lines carry random values so no stale value looks valid
    initial {ctrl_we, ctrl_wdata, key_we, key_wdata, low_store, high_store, store_addr, store_low, store_high} = '0;
    task automatic put_key(input logic [7:0] b);
        @(posedge mclk); #1 key_we = 1'b1; key_wdata = b;
        @(posedge mclk); #1 key_we = 1'b0; key_wdata = 8'($urandom);
    endtask
    task automatic put_ctrl(input logic [15:0] v);
        @(posedge mclk); #1 ctrl_we = 1'b1; ctrl_wdata = v;
        @(posedge mclk); #1 ctrl_we = 1'b0; ctrl_wdata = 16'($urandom);
    endtask
    task automatic put_word(input logic [5:0] a, input logic [15:0] lo, input logic [7:0] hi);
        @(posedge mclk); #1 low_store = 1'b1; store_addr = a; store_low = lo;
        @(posedge mclk); #1 low_store = 1'b0; high_store = 1'b1; store_high = hi; store_low = 16'($urandom);
        @(posedge mclk); #1 high_store = 1'b0; store_addr = 6'($urandom); store_high = 8'($urandom);
    endtask
    task automatic unlock_go(input logic [15:0] v);
        put_key(8'h55);
        put_key(8'hAA);
        put_ctrl(v | 16'h8000);
    endtask
endmodule // fps_core_model

// *** testbench/tb.sv ***
// tb.sv: self-checking bench for fps_sequencer driven through the core model.
// assumes a short self-timed cycle set by CYC.
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fps_pkg::*;
    // long enough for the 64-word row stream to finish inside the cycle
    localparam int unsigned CYC = 72;
    logic mclk = 0, rst_b = 0, abort = 0, ctrl_we, key_we, low_store, high_store;
    logic cpu_stall, array_busy, array_we, op_done;
    logic [15:0] ctrl_wdata, store_low, flash_control_reg;
    logic [7:0] key_wdata, store_high;
    logic [5:0] store_addr, array_addr;
    fps_cmd_t array_cmd;
    fps_word_t array_wdata, mem [64];
    int err_count = 0, n_checks = 0;
    always #2 mclk = ~mclk;
    fps_core_model core (.mclk(mclk), .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata), .key_we(key_we),
        .key_wdata(key_wdata), .low_store(low_store), .high_store(high_store), .store_addr(store_addr),
        .store_low(store_low), .store_high(store_high));
    fps_sequencer #(.CYCLE_CLKS(CYC)) uut (.mclk(mclk), .rst_b(rst_b), .ctrl_we(ctrl_we),
        .ctrl_wdata(ctrl_wdata), .key_we(key_we), .key_wdata(key_wdata), .low_store(low_store),
        .high_store(high_store), .store_addr(store_addr), .store_low(store_low), .store_high(store_high),
        .abort(abort), .flash_control_reg(flash_control_reg), .cpu_stall(cpu_stall),
        .array_busy(array_busy), .array_cmd(array_cmd), .array_we(array_we), .array_addr(array_addr),
        .array_wdata(array_wdata), .op_done(op_done));
    function automatic fps_op_t exp_op(input logic [4:0] c);
        case (c)
            5'h1F: return FPS_BULK_ERASE;
            5'h1D: return FPS_GENERAL_ERASE;
            5'h1C: return FPS_SECURE_ERASE;
            5'h12: return FPS_PAGE_ERASE;
            5'h10, 5'h00: return FPS_CONFIG_ACCESS;
            5'h03: return FPS_WORD_PROGRAM;
            5'h01: return FPS_ROW_PROGRAM;
            default: return FPS_NONE;
        endcase
    endfunction
    task automatic tally_and_finish;
        if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic run_op(input logic [15:0] v, input int exp_words);
        int n;
        int words;
        fps_op_t e;
        e = exp_op({v[6], v[3:0]});
        n = 0;
        words = 0;
        core.unlock_go(v);
        `CHK("stall", 1'b1, cpu_stall)
        `CHK("cmd", e, array_cmd.op)
        `CHK("busy", e != FPS_NONE, array_busy)
        // the core issues nothing while stalled
        while (op_done !== 1'b1 && n < 1000) begin
            if (array_we === 1'b1) begin
                words++;
                `CHK("wdata", mem[array_addr], array_wdata)
            end
            @(posedge mclk); #1 n++;
        end
        `CHK("len", 1'b1, n >= CYC - 2 && n <= CYC + 3)
        `CHK("go", 1'b0, flash_control_reg[15])
        `CHK("fault", 1'b0, flash_control_reg[13])
        `CHK("words", exp_words, words)
    endtask
    task automatic bad_go(input int k);
        case (k)
            0: core.put_ctrl(16'hC042);
            1: begin core.put_key(8'h55); core.put_key(8'($urandom % 85)); core.put_key(8'hAA); end
            2: begin core.put_key(8'h55); core.put_ctrl(16'h4042); core.put_key(8'hAA); core.put_ctrl(16'hC042); end
            default: begin core.put_key(8'h55); core.put_key(8'hAA); core.put_ctrl(16'h8042); end
        endcase
        if (k == 1) core.put_ctrl(16'hC042);
        `CHK("bad_fault", 1'b1, flash_control_reg[13])
        `CHK("bad_stall", 1'b0, cpu_stall)
        abort = 1'($urandom);
        core.put_ctrl(16'h0000);
        abort = 1'b0;
        `CHK("cleared", 16'h0000, flash_control_reg)
    endtask
    initial begin
        int s;
        void'($urandom(57054));
        repeat (12) @(posedge mclk);
        #1 rst_b = 1'b1;
        `CHK("rst_reg", 16'h0000, flash_control_reg)
        core.put_ctrl(16'h5FBF);
        `CHK("wmask", 16'h400F, flash_control_reg)
        for (int k = 0; k < 4; k++) bad_go(k);
        run_op(16'h4042, 0);
        for (int i = 0; i < 64; i++) begin
            mem[i] = 24'($urandom);
            core.put_word(6'(i), mem[i].low_word, mem[i].high_byte);
        end
        run_op(16'h4001, 64);
        s = $urandom % 32;
        for (int j = 0; j < 32; j++) begin
            logic [4:0] c;
            c = 5'((s + j) % 32);
            run_op({2'b01, 7'h00, c[4], 2'b00, c[3:0]}, c == 5'h01 ? 64 : 0);
        end
        core.unlock_go(16'h4042);
        core.put_ctrl(16'h0000);
        `CHK("refused", 16'hC042, flash_control_reg)
        @(posedge mclk); #1 abort = 1'b1;
        @(posedge mclk); #1 abort = 1'b0;
        @(posedge mclk); #1;
        `CHK("abort_fault", 16'h6042, flash_control_reg)
        core.put_ctrl(16'h0000);
        core.unlock_go(16'h4001);
        repeat (4) @(posedge mclk);
        #1 rst_b = 1'b0;
        #1 `CHK("rst_stall", 1'b0, cpu_stall || array_busy || op_done)
        repeat (2) @(posedge mclk);
        #1 rst_b = 1'b1;
        run_op(16'h4042, 0);
        tally_and_finish;
    end
    initial begin
        #100000;
        err_count++;
        tally_and_finish;
    end
endmodule // tb
